/* msfc_pkg.sv */
// msfc_pkg: constants, field layouts and helpers of the measurement core.
// assumes a 40 MHz core clock; all users import the whole package.
package msfc_pkg;
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_NS = 50;
  // longest rejected pulse, rounded down to whole cycles
  localparam logic [1:0] GLITCH_CYC = 2'(GLITCH_NS / CLK_PERIOD_NS);
  // register offsets
  localparam logic [7:0] OFF_CFG_P = 8'h61;
  localparam logic [7:0] OFF_CFG_T2 = 8'h63;
  localparam logic [7:0] OFF_OPER = 8'h64;
  localparam logic [7:0] OFF_LINK = 8'h6C;
  // quantities, in acquisition order
  localparam int unsigned NQ = 3;
  localparam logic [1:0] Q_T2 = 2'h0;
  localparam logic [1:0] Q_T1 = 2'h1;
  localparam logic [1:0] Q_P = 2'h2;
  // configuration word fields
  localparam int unsigned OSR_LSB = 0;
  localparam int unsigned OSR_MSB = 3;
  localparam int unsigned FILT_LSB = 4;
  localparam int unsigned FILT_MSB = 6;
  localparam int unsigned RAT_LSB = 7;
  localparam int unsigned RAT_MSB = 9;
  localparam int unsigned RES_LSB = 10;
  localparam int unsigned RES_MSB = 11;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // operating word fields
  localparam int unsigned DLY_LSB = 0;
  localparam int unsigned DLY_MSB = 3;
  localparam int unsigned FIFO_LSB = 4;
  localparam int unsigned FIFO_MSB = 5;
  localparam int unsigned SELT_BIT = 11;
  localparam logic [15:0] OPER_RST = 16'h0000;
  // link settings word fields
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned ADDR_MSB = 5;
  localparam int unsigned GLITCH_BIT = 7;
  localparam int unsigned CHAIN_BIT = 8;
  localparam logic [15:0] LINK_RST = 16'h00BA;
  localparam logic [15:0] LINK_MASK = 16'h01BF;
  // command opcodes (command byte bits 7:1, bit 0 is the check bit)
  localparam logic [6:0] CMD_WOPER = 7'h0A;
  localparam logic [6:0] CMD_ROPER = 7'h0B;
  localparam logic [6:0] CMD_START = 7'h0C;
  localparam logic [6:0] CMD_STOP = 7'h0D;
  localparam logic [6:0] CMD_CONV = 7'h27;
  localparam logic [6:0] CMD_WREG = 7'h70;
  localparam logic [6:0] CMD_RREG = 7'h71;
  localparam logic [4:0] CMD_WCFG = 5'h04;
  localparam logic [4:0] CMD_RCFG = 5'h05;
  localparam logic [3:0] CMD_RADC = 4'h5;
  localparam logic [1:0] A_NONE = 2'h3;
  // code limits and widths
  localparam logic [2:0] RAT_TOP = 3'h7;
  localparam logic [6:0] RATIO_MAX = 7'h40;
  localparam logic [3:0] OSR_MAX = 4'h9;
  localparam logic [4:0] W24 = 5'h18;
  localparam logic [4:0] W16 = 5'h10;
  localparam logic [4:0] W8 = 5'h08;
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned MEAN_FRAC = 8;
  localparam int unsigned RD_W = 72;
  // autonomous delay per code, in microseconds (code 0 is off)
  localparam logic [31:0] DLY_US_TAB [16] = '{
    32'h0, 32'h0, 32'h3E8, 32'h1388, 32'h2710, 32'h4E20, 32'hC350,
    32'h186A0, 32'h30D40, 32'h7A120, 32'hF4240, 32'h1E8480,
    32'h4C4B40, 32'h989680, 32'h1312D00, 32'h3938700};

  function automatic logic [6:0] ratio_of(input logic [2:0] c);
    ratio_of = (c == RAT_TOP) ? RATIO_MAX : 7'(7'h01 << c);
  endfunction : ratio_of

  function automatic logic [3:0] osr_lvl(input logic [3:0] c);
    osr_lvl = (c > OSR_MAX) ? OSR_MAX : c;
  endfunction : osr_lvl

  function automatic logic [4:0] width_of(input logic [1:0] c);
    width_of = (c == 2'h0) ? W24 : ((c == 2'h1) ? W16 : W8);
  endfunction : width_of
endpackage : msfc_pkg

/* msfc_iir.sv */
// msfc_iir: first-order smoothing filter, one running mean per quantity.
// assumes one sample per in_valid_i pulse, all on the core clock.
`timescale 1ns/1ps
module msfc_iir import msfc_pkg::*; #(
  parameter int unsigned DW = SAMPLE_W,
  parameter int unsigned FW = MEAN_FRAC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  input wire logic [1:0] in_quant_i,
  input wire logic [DW-1:0] in_data_i,
  input wire logic [2:0] k_code_i,
  output logic out_valid_o,
  output logic [1:0] out_quant_o,
  output logic [DW-1:0] out_data_o
);
  typedef struct packed {
    logic [NQ-1:0][DW+FW-1:0] mean;
    logic vld;
    logic [1:0] q;
    logic [DW-1:0] dat;
  } msfc_iir_s_t;

  msfc_iir_s_t s;
  msfc_iir_s_t next_s;

  // fraction bits keep small steps from vanishing at large k
  always_comb begin
    logic [DW+FW-1:0] m;
    logic [DW+FW-1:0] x;
    m = '0;
    x = '0;
    next_s = s;
    next_s.vld = 1'b0;
    if (in_valid_i && (in_quant_i < 2'(NQ))) begin
      m = s.mean[in_quant_i];
      x = {in_data_i, {FW{1'b0}}};
      if (k_code_i == 3'h0) begin
        m = x; // off: mean follows the sample
      end else begin
        m = m - (m >> k_code_i) + (x >> k_code_i);
      end
      next_s.mean[in_quant_i] = m;
      next_s.dat = m[DW+FW-1:FW];
      next_s.q = in_quant_i;
      next_s.vld = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_valid_o = s.vld;
  assign out_quant_o = s.q;
  assign out_data_o = s.dat;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_filt_off;
    in_valid_i && k_code_i == 3'h0 && in_quant_i < 2'(NQ)
      |=> out_valid_o && out_data_o == $past(in_data_i);
  endproperty
  a_filt_off: assert property (p_filt_off)
    else $error("filter off does not pass the sample");

  // a mean seeded with the sample value must not move on that sample
  property p_filt_step;
    in_valid_i && k_code_i != 3'h0 && in_quant_i < 2'(NQ)
      && s.mean[in_quant_i] == {in_data_i, {FW{1'b0}}}
      |=> out_valid_o && out_data_o == $past(in_data_i);
  endproperty
  a_filt_step: assert property (p_filt_step)
    else $error("seeded mean moved without new input");
endmodule : msfc_iir

/* msfc_core.sv */
// msfc_core: measurement scheduler, register set and readout packing.
// assumes a command decoder that presents one command per cmd_valid_i
// pulse with its check bit already verified, and an adc on ref_clk_i.
`timescale 1ns/1ps
module msfc_core import msfc_pkg::*; #(
  parameter int unsigned US_CYC = CYC_PER_US,
  parameter int unsigned DLY_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic cmd_accept_o,
  output logic cmd_reject_o,
  output logic [15:0] cmd_rdata_o,
  output logic [RD_W-1:0] res_data_o,
  output logic [6:0] res_bits_o,
  input wire logic address_select_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_filt_o,
  output logic sda_filt_o,
  output logic [6:0] dev_addr_o,
  output logic chain_mode_o,
  output logic glitch_en_o,
  output logic conv_start_o,
  output logic [1:0] conv_quant_o,
  output logic [3:0] conv_osr_o,
  input wire logic conv_done_i,
  input wire logic [SAMPLE_W-1:0] conv_data_i,
  output logic fifo_push_o,
  output logic [SAMPLE_W-1:0] fifo_temp_o,
  output logic [SAMPLE_W-1:0] fifo_pres_o,
  output logic busy_o,
  output logic auto_on_o
);
  typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT} msfc_st_t;

  typedef struct packed {
    logic [NQ-1:0][15:0] cfg;
    logic [NQ-1:0][15:0] act;
    logic [15:0] oper;
    logic [15:0] link;
    logic auto_on;
    msfc_st_t st;
    logic [NQ-1:0] due;
    logic [NQ-1:0][5:0] cnt;
    logic [31:0] tmr;
    logic [1:0] q;
    logic [3:0] osr;
    logic start;
    logic [NQ-1:0][SAMPLE_W-1:0] res;
    logic [15:0] rdata;
    logic [RD_W-1:0] rd;
    logic [6:0] rbits;
    logic push;
    logic [SAMPLE_W-1:0] ftemp;
    logic [SAMPLE_W-1:0] fpres;
    logic pin_s1;
    logic pin_s2;
    logic [1:0] bus_s1;
    logic [1:0] bus_s2;
    logic [1:0] bus_lvl;
    logic [1:0][1:0] bus_cnt;
  } msfc_core_s_t;

  // bus lines idle high, so their synchronisers start high
  localparam msfc_core_s_t S_RST = '{
    cfg: {NQ{CFG_RST}}, act: {NQ{CFG_RST}}, oper: OPER_RST,
    link: LINK_RST, st: S_IDLE, bus_s1: 2'h3, bus_s2: 2'h3,
    bus_lvl: 2'h3, default: '0};

  // readout order: temperatures first, pressure last
  localparam logic [1:0] RD_ORDER [NQ] = '{Q_T1, Q_T2, Q_P};

  msfc_core_s_t s;
  msfc_core_s_t next_s;

  logic [6:0] op;
  logic [7:0] roff;
  logic reg_cfg;
  logic reg_ok;
  logic is_wcfg;
  logic is_rcfg;
  logic is_radc;
  logic is_wreg;
  logic is_rreg;
  logic cfg_wr;
  logic known;
  logic locked;
  logic acc;
  logic [1:0] cfg_q;
  logic [NQ-1:0] cyc_due;
  logic [3:0] dly_code;
  logic [4:0] p_width;
  logic f_valid;
  logic [1:0] f_quant;
  logic [SAMPLE_W-1:0] f_data;

  function automatic logic [1:0] cfg_of(input logic [1:0] a);
    cfg_of = (a == 2'h0) ? Q_P : ((a == 2'h1) ? Q_T1 : Q_T2);
  endfunction : cfg_of

  function automatic logic [1:0] first_q(input logic [NQ-1:0] d);
    first_q = d[Q_T2] ? Q_T2 : (d[Q_T1] ? Q_T1 : Q_P);
  endfunction : first_q

  // delay cycles; DLY_DIV only exists to shorten simulation
  function automatic logic [31:0] dly_cyc(input logic [3:0] c);
    dly_cyc = 32'((64'(DLY_US_TAB[c]) * 64'(US_CYC)) / 64'(DLY_DIV));
  endfunction : dly_cyc

  // command decode; the check bit is not looked at here
  always_comb begin
    op = cmd_byte_i[7:1];
    roff = cmd_addr_i - OFF_CFG_P;
    reg_cfg = (cmd_addr_i >= OFF_CFG_P) && (cmd_addr_i <= OFF_CFG_T2);
    reg_ok = reg_cfg || cmd_addr_i == OFF_OPER || cmd_addr_i == OFF_LINK;
    is_wcfg = op[6:2] == CMD_WCFG && op[1:0] != A_NONE;
    is_rcfg = op[6:2] == CMD_RCFG && op[1:0] != A_NONE;
    is_radc = op[6:3] == CMD_RADC && op[2:0] != 3'h0;
    is_wreg = op == CMD_WREG && reg_ok;
    is_rreg = op == CMD_RREG && reg_ok;
    cfg_wr = is_wcfg || (is_wreg && reg_cfg);
    cfg_q = (is_wcfg || is_rcfg) ? cfg_of(op[1:0]) : cfg_of(roff[1:0]);
    known = is_wcfg || is_rcfg || is_radc || is_wreg || is_rreg
      || op == CMD_WOPER || op == CMD_ROPER || op == CMD_START
      || op == CMD_STOP || op == CMD_CONV;
    locked = s.auto_on || s.st != S_IDLE;
    acc = cmd_valid_i && known
      && !((cfg_wr || op == CMD_CONV) && locked);
  end

  // helpers shared by the scheduler and the checks
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      cyc_due[i] = s.cnt[i] == 6'h00;
    end
    dly_code = s.oper[DLY_MSB:DLY_LSB];
    p_width = width_of(s.act[Q_P][RES_MSB:RES_LSB]);
  end

  // next state of the whole core
  always_comb begin
    logic go;
    logic fin;
    logic iss;
    logic [RD_W-1:0] pk;
    logic [6:0] n;
    logic [4:0] w;
    logic [NQ-1:0] sel;
    logic [6:0] nx;
    logic [1:0] q;
    go = 1'b0;
    fin = 1'b0;
    iss = 1'b0;
    pk = '0;
    n = '0;
    w = '0;
    sel = {cmd_byte_i[1], cmd_byte_i[2], cmd_byte_i[3]};
    nx = '0;
    q = '0;
    next_s = s;
    next_s.start = 1'b0;
    next_s.push = 1'b0;
    // pin and bus synchronisers
    next_s.pin_s1 = address_select_pin_i;
    next_s.pin_s2 = s.pin_s1;
    next_s.bus_s1 = {sda_i, scl_i};
    next_s.bus_s2 = s.bus_s1;
    // a level must differ for more than GLITCH_CYC samples to pass
    for (int i = 0; i < 2; i++) begin
      if (s.bus_s2[i] == s.bus_lvl[i]) begin
        next_s.bus_cnt[i] = 2'h0;
      end else if (!s.link[GLITCH_BIT] || s.bus_cnt[i] == GLITCH_CYC) begin
        next_s.bus_lvl[i] = s.bus_s2[i];
        next_s.bus_cnt[i] = 2'h0;
      end else begin
        next_s.bus_cnt[i] = s.bus_cnt[i] + 2'h1;
      end
    end
    // register commands
    if (acc) begin
      if (cfg_wr) begin
        next_s.cfg[cfg_q] = cmd_wdata_i;
      end
      if (is_rcfg || (is_rreg && reg_cfg)) begin
        next_s.rdata = s.cfg[cfg_q];
      end
      if (is_wreg && cmd_addr_i == OFF_LINK) begin
        next_s.link = cmd_wdata_i & LINK_MASK;
      end
      if (is_rreg && cmd_addr_i == OFF_LINK) begin
        next_s.rdata = s.link;
      end
      if (op == CMD_WOPER || (is_wreg && cmd_addr_i == OFF_OPER)) begin
        next_s.oper = cmd_wdata_i;
        next_s.auto_on = cmd_wdata_i[DLY_MSB:DLY_LSB] != 4'h0;
        if (!s.auto_on) begin
          next_s.cnt = '0;
        end
      end
      if (op == CMD_ROPER || (is_rreg && cmd_addr_i == OFF_OPER)) begin
        next_s.rdata = s.oper;
      end
      if (op == CMD_START && dly_code != 4'h0) begin
        next_s.auto_on = 1'b1;
        if (!s.auto_on) begin
          next_s.cnt = '0;
        end
      end
      if (op == CMD_STOP) begin
        next_s.auto_on = 1'b0;
      end
      // pack the selected results, each cut to its own width
      if (is_radc) begin
        for (int i = 0; i < NQ; i++) begin
          q = RD_ORDER[i];
          w = width_of(s.act[q][RES_MSB:RES_LSB]);
          if (sel[q]) begin
            pk = (pk << w) | RD_W'(s.res[q] >> (W24 - w));
            n = n + 7'(w);
          end
        end
        next_s.rd = pk << (7'(RD_W) - n);
        next_s.rbits = n;
      end
    end
    // scheduler
    unique case (s.st)
      S_IDLE: begin
        if (s.auto_on) begin
          go = 1'b1;
        end else if (acc && op == CMD_CONV) begin
          next_s.act = s.cfg;
          next_s.due = '1;
          iss = 1'b1;
        end
      end
      S_CONV: begin
        if (conv_done_i) begin
          next_s.due[s.q] = 1'b0;
          if (next_s.due != '0) begin
            iss = 1'b1;
          end else begin
            fin = 1'b1;
          end
        end
      end
      S_WAIT: begin
        if (!s.auto_on) begin
          next_s.st = S_IDLE;
        end else if (s.tmr == 32'h0) begin
          go = 1'b1;
        end else begin
          next_s.tmr = s.tmr - 32'h1;
        end
      end
    endcase
    // cycle boundary: latch settings, advance the ratio counters
    if (go) begin
      next_s.act = s.cfg;
      next_s.due = cyc_due;
      for (int i = 0; i < NQ; i++) begin
        nx = {1'b0, s.cnt[i]} + 7'h01;
        next_s.cnt[i] = (nx >= ratio_of(s.cfg[i][RAT_MSB:RAT_LSB]))
          ? 6'h00 : nx[5:0];
      end
      if (cyc_due == '0) begin
        next_s.tmr = dly_cyc(dly_code);
        next_s.st = S_WAIT;
      end else begin
        iss = 1'b1;
      end
    end
    // end of a measurement cycle: wait or stop
    if (fin) begin
      if (s.auto_on) begin
        next_s.tmr = dly_cyc(dly_code);
        next_s.st = S_WAIT;
      end else begin
        next_s.st = S_IDLE;
      end
    end
    // start the next due quantity, lowest index first
    if (iss) begin
      next_s.q = first_q(next_s.due);
      next_s.osr = osr_lvl(next_s.act[next_s.q][OSR_MSB:OSR_LSB]);
      next_s.start = 1'b1;
      next_s.st = S_CONV;
    end
    // filtered results; the queue gets the temperature chosen by SELT_BIT as well
    if (f_valid && f_quant < 2'(NQ)) begin
      next_s.res[f_quant] = f_data;
      if (f_quant == Q_P && s.oper[FIFO_MSB:FIFO_LSB] != 2'h0) begin
        next_s.push = 1'b1;
        next_s.fpres = f_data;
        next_s.ftemp = s.oper[SELT_BIT] ? s.res[Q_T2] : s.res[Q_T1];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= S_RST;
    end else begin
      s <= next_s;
    end
  end

  // filter sees only results of conversions this core started
  msfc_iir #(
    .DW(SAMPLE_W),
    .FW(MEAN_FRAC)
  ) i_msfc_iir (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(conv_done_i && s.st == S_CONV),
    .in_quant_i(s.q),
    .in_data_i(conv_data_i),
    .k_code_i(s.act[s.q][FILT_MSB:FILT_LSB]),
    .out_valid_o(f_valid),
    .out_quant_o(f_quant),
    .out_data_o(f_data)
  );

  // outputs
  assign cmd_accept_o = acc;
  assign cmd_reject_o = cmd_valid_i && !acc;
  assign cmd_rdata_o = s.rdata;
  assign res_data_o = s.rd;
  assign res_bits_o = s.rbits;
  assign scl_filt_o = s.bus_lvl[0];
  assign sda_filt_o = s.bus_lvl[1];
  assign dev_addr_o = {s.link[ADDR_MSB:ADDR_LSB], ~s.pin_s2};
  assign chain_mode_o = s.link[CHAIN_BIT];
  assign glitch_en_o = s.link[GLITCH_BIT];
  assign conv_start_o = s.start;
  assign conv_quant_o = s.q;
  assign conv_osr_o = s.osr;
  assign fifo_push_o = s.push;
  assign fifo_temp_o = s.ftemp;
  assign fifo_pres_o = s.fpres;
  assign busy_o = s.st == S_CONV;
  assign auto_on_o = s.auto_on;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_cfg_lock;
    cmd_valid_i && cfg_wr && locked |=> $stable(s.cfg);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("configuration changed while locked");

  property p_order;
    conv_start_o && conv_quant_o == Q_P |-> !s.due[Q_T2] && !s.due[Q_T1];
  endproperty
  a_order: assert property (p_order)
    else $error("pressure converted before a due temperature");

  property p_osr;
    conv_start_o |-> conv_osr_o <= OSR_MAX;
  endproperty
  a_osr: assert property (p_osr)
    else $error("oversampling level above the cap");

  property p_idle_event;
    s.st == S_WAIT && s.auto_on && s.tmr == 32'h0 && cyc_due == '0
      |=> !conv_start_o && s.st == S_WAIT;
  endproperty
  a_idle_event: assert property (p_idle_event)
    else $error("conversion started with nothing due");

  property p_wrap;
    s.st == S_WAIT && s.auto_on && s.tmr == 32'h0
      |=> 7'(s.cnt[Q_P]) < ratio_of(s.act[Q_P][RAT_MSB:RAT_LSB]);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("ratio counter passed its wrap point");

  property p_wait_len;
    $rose(s.st == S_WAIT) |-> s.tmr == dly_cyc($past(dly_code));
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("wait not loaded from the delay field");

  property p_pair;
    fifo_push_o |-> fifo_pres_o == s.res[Q_P]
      && s.oper[FIFO_MSB:FIFO_LSB] != 2'h0;
  endproperty
  a_pair: assert property (p_pair)
    else $error("queue entry without matching pressure");

  property p_rd_len;
    acc && is_radc && cmd_byte_i[3:1] == 3'h1
      |=> res_bits_o == 7'($past(p_width));
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("pressure readout length wrong");

  property p_glitch;
    glitch_en_o && $changed(scl_filt_o)
      |-> $past(s.bus_s2[0], 1) == scl_filt_o
        && $past(s.bus_s2[0], 3) == scl_filt_o;
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("short bus pulse passed the filter");

  property p_addr;
    $rose(s.pin_s2) |-> dev_addr_o[0] == 1'b0;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address bit 0 does not invert the pin");
endmodule : msfc_core

/* msfc_adc_model.sv */
// msfc_adc_model: behavioural converter that answers each start pulse.
// assumes one conversion at a time, all on the core clock.
`timescale 1ns/1ps
module msfc_adc_model #(
  parameter int LAT = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [1:0] quant_i,
  output logic done_o,
  output logic [23:0] data_o
);
  int cnt;
  logic [1:0] q;
  // conversion time counter; quantity held for the result pattern
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      q <= 2'h0;
    end else if (start_i) begin
      cnt <= LAT;
      q <= quant_i;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  // outside the done cycle the data lines show the inverse, never stale
  assign done_o = (cnt == 1);
  assign data_o = done_o ? {4'h9, 2'h0, q, 16'h5A3C}
    : ~{4'h9, 2'h0, q, 16'h5A3C};
endmodule : msfc_adc_model

/* msfc_core_test.sv */
// msfc_core_test: self-checking bench of the measurement core.
// assumes msfc_pkg compiled first and the adc model beside the core.
`timescale 1ns/1ps
module msfc_core_test;
  import msfc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cv = 1'b0, pin = 1'b0, scl = 1'b1, sda = 1'b1;
  logic [7:0] cb = 8'h00, ca = 8'h00;
  logic [15:0] cw = 16'h0000, rdata;
  logic acc, rej, sclf, sdaf, chain, glt, start, push, busy, auto, done;
  logic [RD_W-1:0] res;
  logic [6:0] bits, dev;
  logic [1:0] qnt;
  logic [3:0] osr;
  logic [23:0] cdata, ftemp, fpres;
  logic [5:0] conv_log = 6'h00;
  int mismatches = 0, compares = 0, n[3];
  msfc_core #(.DLY_DIV(1000)) i_msfc_core (.ref_clk_i(clk), .sys_rst_i(rst),
    .cmd_valid_i(cv), .cmd_byte_i(cb), .cmd_addr_i(ca), .cmd_wdata_i(cw),
    .cmd_accept_o(acc), .cmd_reject_o(rej), .cmd_rdata_o(rdata),
    .res_data_o(res), .res_bits_o(bits), .address_select_pin_i(pin),
    .scl_i(scl), .sda_i(sda), .scl_filt_o(sclf), .sda_filt_o(sdaf),
    .dev_addr_o(dev), .chain_mode_o(chain), .glitch_en_o(glt),
    .conv_start_o(start), .conv_quant_o(qnt), .conv_osr_o(osr),
    .conv_done_i(done), .conv_data_i(cdata), .fifo_push_o(push),
    .fifo_temp_o(ftemp), .fifo_pres_o(fpres), .busy_o(busy),
    .auto_on_o(auto));
  msfc_adc_model i_msfc_adc_model (.clk_i(clk), .rst_i(rst), .start_i(start),
    .quant_i(qnt), .done_o(done), .data_o(cdata));
  always #12.5 clk = ~clk;
  // bus clock runs free at 200.6 ns, phase unrelated to the core clock
  always #100.3 scl = ~scl;
  task automatic check(input string nm, input logic [71:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic print_verdict;
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // one command per call; accept is settled 1 ns after launch
  task automatic cmd(input logic [7:0] b, a, input logic [15:0] d,
    input logic ex);
    @(posedge clk);
    cv <= 1'b1; cb <= b; ca <= a; cw <= d;
    #1 check("accept", acc, ex);
    check("reject", rej, !ex);
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask : cmd
  // conversion log, osr mapping, per-quantity tallies and fifo pairs
  always @(posedge clk) begin
    if (start) begin
      conv_log <= {conv_log[3:0], qnt};
      n[qnt]++;
      if (qnt == Q_P) check("osr", osr, 4'h9);
    end
    if (push) check("fifo_temp", ftemp, 24'h915A3C);
    if (push) check("fifo_pres", fpres, 24'h925A3C);
  end
  task automatic t_glitch;
    @(posedge clk) sda <= 1'b0;
    @(posedge clk) sda <= 1'b1;
    repeat (6) @(posedge clk) check("sda_short", sdaf, 1'b1);
    sda <= 1'b0;
    repeat (8) @(posedge clk);
    check("sda_long", sdaf, 1'b0);
    sda <= 1'b1;
  endtask : t_glitch
  task automatic t_link;
    check("dev_rst", dev, 7'h75);
    check("chain_rst", chain, 1'b0);
    check("glitch_rst", glt, 1'b1);
    cmd(8'hE2, 8'h6C, 16'h0, 1'b1);
    check("link_rst", rdata, 16'h00BA);
    cmd(8'hE0, 8'h6C, 16'hFFFF, 1'b1);
    cmd(8'hE2, 8'h6C, 16'h0, 1'b1);
    check("link_rd", rdata, 16'h01BF);
    check("chain_on", chain, 1'b1);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    check("dev_pin", dev, 7'h7E);
    cmd(8'hE2, 8'h70, 16'h0, 1'b0);
    cmd(8'hE0, 8'h6C, 16'h00BA, 1'b1);
  endtask : t_link
  task automatic t_conv;
    cmd(8'hE0, 8'h63, 16'h0080, 1'b1);
    cmd(8'hE0, 8'h62, 16'h0505, 1'b1);
    cmd(8'hE0, 8'h61, 16'h008C, 1'b1);
    cmd(8'h4E, 8'h00, 16'h0, 1'b1);
    cmd(8'hE0, 8'h61, 16'h0000, 1'b0);
    cmd(8'h4E, 8'h00, 16'h0, 1'b0);
    repeat (200) if (busy !== 1'b0) @(posedge clk);
    check("order", conv_log, 6'b000110);
    cmd(8'h56, 8'h00, 16'h0, 1'b1);
    check("bits", bits, 7'd40);
    check("t1_p", res[71:32], 40'h915A925A3C);
    cmd(8'h52, 8'h00, 16'h0, 1'b1);
    check("p_bits", bits, 7'd24);
    check("p_only", res[71:48], 24'h925A3C);
    cmd(8'h50, 8'h00, 16'h0, 1'b0);
  endtask : t_conv
  task automatic t_auto;
    n = '{0, 0, 0};
    // filter was off for the last conversion, so its mean is already seeded with that sample
    cmd(8'hE0, 8'h63, 16'h0090, 1'b1);
    cmd(8'hE0, 8'h64, 16'h0011, 1'b1);
    check("auto_on", auto, 1'b1);
    cmd(8'hE0, 8'h62, 16'h0000, 1'b0);
    repeat (3000) if (n[2] < 8) @(posedge clk);
    check("t2_count", n[0], 8);
    check("t1_count", n[1], 4);
    cmd(8'h1A, 8'h00, 16'h0, 1'b1);
    repeat (200) if (busy !== 1'b0) @(posedge clk);
    check("auto_off", auto, 1'b0);
  endtask : t_auto
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_glitch();
    t_link();
    t_conv();
    t_auto();
    print_verdict();
  end
  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
endmodule : msfc_core_test
